// ### src/prc_pkg.sv
// Constants shared by the peripheral reset control block
//
// How it works
// - AHB2 reset register at 0x14, reset zero; bits 0,1,4-7 used.
// - A bit at one holds its peripheral in reset; zero leaves it alone.
// - AHB3 reset register at 0x18, reset zero; bit 0 is memory controller.
// - APB1 reset register at 0x20, reset zero; timer, serial, bus bits.
// - Word, halfword and byte writes, answered with no wait state while ce is high.
// - Software can write any APB1 bit back to zero, releasing reset.
package prc_pkg;

    // ------------------------------------------------------------------
    // Register offsets, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] AHB2_RST_OFS = 8'h14;
    localparam logic [7:0] AHB3_RST_OFS = 8'h18;
    localparam logic [7:0] APB1_RST_OFS = 8'h20;

    // ------------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------------
    localparam logic [31:0] AHB2_RST_VAL  = 32'h0000_0000;
    localparam logic [31:0] AHB3_RST_VAL  = 32'h0000_0000;
    localparam logic [31:0] APB1_RST_VAL  = 32'h0000_0000;
    localparam logic [31:0] AHB2_RST_MASK = 32'h0000_00f3;
    localparam logic [31:0] AHB3_RST_MASK = 32'h0000_0001;
    localparam logic [31:0] APB1_RST_MASK = 32'h36fe_c9ff;

    // ------------------------------------------------------------------
    // Field positions, AHB2 register
    // ------------------------------------------------------------------
    localparam int CAMERA_IF_BIT = 0;
    localparam int FLOAT_UNIT_BIT = 1;
    localparam int CIPHER_BIT = 4;
    localparam int DIGEST_BIT = 5;
    localparam int RANDOM_GEN_BIT = 6;
    localparam int USB_FS_BIT = 7;

    // Field position, AHB3 register
    localparam int EXT_MEMCTL_BIT = 0;

    // ------------------------------------------------------------------
    // Field positions, APB1 register (timers 2..7,12..14 are 0..8)
    // ------------------------------------------------------------------
    localparam int TIMER_FIRST_BIT = 0;
    localparam int WWDG_BIT = 11;
    localparam int SERIAL2_BIT = 14;
    localparam int SERIAL3_BIT = 15;
    localparam int SYNC_PORT2_BIT = 17;
    localparam int SYNC_PORT3_BIT = 18;
    localparam int ASYNC_PORT4_BIT = 19;
    localparam int ASYNC_PORT5_BIT = 20;
    localparam int TWO_WIRE1_BIT = 21;
    localparam int TWO_WIRE2_BIT = 22;
    localparam int TWO_WIRE3_BIT = 23;
    localparam int FIELDBUS1_BIT = 25;
    localparam int FIELDBUS2_BIT = 26;
    localparam int POWER_IF_BIT = 28;
    localparam int DAC_IF_BIT = 29;

endpackage : prc_pkg

// ### src/prc_word.sv
// One 32-bit reset register with byte-lane writes and a writable mask
`timescale 1ns/10ps
module prc_word
    import prc_pkg::*;
#(
    parameter logic [31:0] MASK  = 32'hffff_ffff,
    parameter logic [31:0] RESET = 32'h0000_0000
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        wr_en,
    input  wire logic [3:0]  be,
    input  wire logic [31:0] wdata,
    output logic      [31:0] value
);

    typedef struct packed {
        logic [31:0] value;
    } prc_word_state_t;

    prc_word_state_t state_reg;
    prc_word_state_t state_next;

    // Spread the byte strobes over their lanes
    function automatic logic [31:0] lane_bits(input logic [3:0] b);
        return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction

    // ------------------------------------------------------------------
    // Next value
    // ------------------------------------------------------------------
    // Only strobed lanes change; reserved bits stay zero for good
    always_comb begin
        logic [31:0] keep;
        keep = lane_bits(be) & MASK;
        state_next = state_reg;
        if (wr_en) begin
            state_next.value = (state_reg.value & ~keep)
                             | (wdata & keep);
        end
    end

    // Register the state; a low clock enable freezes it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg.value <= RESET;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.value;

endmodule // prc_word

// ### src/prc_top.sv
// Peripheral reset control: three software reset registers
`timescale 1ns/10ps
module prc_top
    import prc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        reg_sel,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [3:0]  reg_be,
    input  wire logic [31:0] reg_wdata,
    output logic             reg_ack,
    output logic      [31:0] reg_rdata,
    output logic             camera_if_reset,
    output logic             float_unit_reset,
    output logic             cipher_reset,
    output logic             digest_engine_reset,
    output logic             random_gen_reset,
    output logic             usb_fullspeed_reset,
    output logic             ext_memctl_reset,
    output logic             timer2_reset,
    output logic             timer3_reset,
    output logic             timer4_reset,
    output logic             timer5_reset,
    output logic             timer6_reset,
    output logic             timer7_reset,
    output logic             timer12_reset,
    output logic             timer13_reset,
    output logic             timer14_reset,
    output logic             window_watchdog_reset,
    output logic             serial_periph2_reset,
    output logic             serial_periph3_reset,
    output logic             sync_async_port2_reset,
    output logic             sync_async_port3_reset,
    output logic             async_port4_reset,
    output logic             async_port5_reset,
    output logic             two_wire1_reset,
    output logic             two_wire2_reset,
    output logic             two_wire3_reset,
    output logic             fieldbus1_reset,
    output logic             fieldbus2_reset,
    output logic             power_if_reset,
    output logic             dac_if_reset
);

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } prc_bus_state_t;

    prc_bus_state_t state_reg;
    prc_bus_state_t state_next;

    logic [31:0] ahb2_periph_reset;
    logic [31:0] ahb3_periph_reset;
    logic [31:0] apb1_periph_reset;
    logic        wr_ahb2;
    logic        wr_ahb3;
    logic        wr_apb1;

    // Word match; the two low address bits are covered by the strobes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a[7:2] == o[7:2];
    endfunction

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Unmapped writes fall through and are dropped, still acknowledged
    assign wr_ahb2 = reg_sel && reg_wr && hit(reg_addr, AHB2_RST_OFS);
    assign wr_ahb3 = reg_sel && reg_wr && hit(reg_addr, AHB3_RST_OFS);
    assign wr_apb1 = reg_sel && reg_wr && hit(reg_addr, APB1_RST_OFS);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    prc_word #(.MASK(AHB2_RST_MASK), .RESET(AHB2_RST_VAL)) u_ahb2 (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .wr_en (wr_ahb2),
        .be    (reg_be),
        .wdata (reg_wdata),
        .value (ahb2_periph_reset)
    );

    prc_word #(.MASK(AHB3_RST_MASK), .RESET(AHB3_RST_VAL)) u_ahb3 (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .wr_en (wr_ahb3),
        .be    (reg_be),
        .wdata (reg_wdata),
        .value (ahb3_periph_reset)
    );

    prc_word #(.MASK(APB1_RST_MASK), .RESET(APB1_RST_VAL)) u_apb1 (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .wr_en (wr_apb1),
        .be    (reg_be),
        .wdata (reg_wdata),
        .value (apb1_periph_reset)
    );

    // ------------------------------------------------------------------
    // Bus answer: acknowledge every access made with ce high on the next edge
    // ------------------------------------------------------------------
    // Read data is sampled before any write of the same cycle lands
    always_comb begin
        state_next = state_reg;
        state_next.ack = reg_sel;
        state_next.rdata = 32'h0000_0000;
        if (reg_sel && !reg_wr) begin
            if (hit(reg_addr, AHB2_RST_OFS)) begin
                state_next.rdata = ahb2_periph_reset;
            end else if (hit(reg_addr, AHB3_RST_OFS)) begin
                state_next.rdata = ahb3_periph_reset;
            end else if (hit(reg_addr, APB1_RST_OFS)) begin
                state_next.rdata = apb1_periph_reset;
            end
        end
    end

    // Bus answer flops, frozen with the rest when the enable is low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign reg_ack   = state_reg.ack;
    assign reg_rdata = state_reg.rdata;

    // ------------------------------------------------------------------
    // Reset lines, straight from the register flops
    // ------------------------------------------------------------------
    // A one holds the peripheral in reset until software clears it
    assign camera_if_reset      = ahb2_periph_reset[CAMERA_IF_BIT];
    assign float_unit_reset     = ahb2_periph_reset[FLOAT_UNIT_BIT];
    assign cipher_reset         = ahb2_periph_reset[CIPHER_BIT];
    assign digest_engine_reset  = ahb2_periph_reset[DIGEST_BIT];
    assign random_gen_reset     = ahb2_periph_reset[RANDOM_GEN_BIT];
    assign usb_fullspeed_reset  = ahb2_periph_reset[USB_FS_BIT];
    assign ext_memctl_reset     = ahb3_periph_reset[EXT_MEMCTL_BIT];
    assign timer2_reset  = apb1_periph_reset[TIMER_FIRST_BIT];
    assign timer3_reset  = apb1_periph_reset[TIMER_FIRST_BIT + 1];
    assign timer4_reset  = apb1_periph_reset[TIMER_FIRST_BIT + 2];
    assign timer5_reset  = apb1_periph_reset[TIMER_FIRST_BIT + 3];
    assign timer6_reset  = apb1_periph_reset[TIMER_FIRST_BIT + 4];
    assign timer7_reset  = apb1_periph_reset[TIMER_FIRST_BIT + 5];
    assign timer12_reset = apb1_periph_reset[TIMER_FIRST_BIT + 6];
    assign timer13_reset = apb1_periph_reset[TIMER_FIRST_BIT + 7];
    assign timer14_reset = apb1_periph_reset[TIMER_FIRST_BIT + 8];
    assign window_watchdog_reset  = apb1_periph_reset[WWDG_BIT];
    assign serial_periph2_reset   = apb1_periph_reset[SERIAL2_BIT];
    assign serial_periph3_reset   = apb1_periph_reset[SERIAL3_BIT];
    assign sync_async_port2_reset = apb1_periph_reset[SYNC_PORT2_BIT];
    assign sync_async_port3_reset = apb1_periph_reset[SYNC_PORT3_BIT];
    assign async_port4_reset      = apb1_periph_reset[ASYNC_PORT4_BIT];
    assign async_port5_reset      = apb1_periph_reset[ASYNC_PORT5_BIT];
    assign two_wire1_reset        = apb1_periph_reset[TWO_WIRE1_BIT];
    assign two_wire2_reset        = apb1_periph_reset[TWO_WIRE2_BIT];
    assign two_wire3_reset        = apb1_periph_reset[TWO_WIRE3_BIT];
    assign fieldbus1_reset        = apb1_periph_reset[FIELDBUS1_BIT];
    assign fieldbus2_reset        = apb1_periph_reset[FIELDBUS2_BIT];
    assign power_if_reset         = apb1_periph_reset[POWER_IF_BIT];
    assign dac_if_reset           = apb1_periph_reset[DAC_IF_BIT];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Full-word write of a given register while enabled
    sequence s_word_wr(logic hitw);
        hitw && ce && reg_be == 4'hf;
    endsequence

    chk_ahb2_reserved: assert property (
        (ahb2_periph_reset & ~AHB2_RST_MASK) == 32'h0000_0000
    ) else $error("AHB2 reserved bit set");

    chk_set_asserts: assert property (
        s_word_wr(wr_ahb2) |=>
            camera_if_reset == $past(reg_wdata[CAMERA_IF_BIT])
    ) else $error("Camera reset does not follow written bit");

    chk_ahb3_reserved: assert property (
        ahb3_periph_reset[31:1] == 31'h0000_0000
    ) else $error("AHB3 reserved bit set");

    chk_apb1_readback: assert property (
        reg_sel && ce && !reg_wr && hit(reg_addr, APB1_RST_OFS) |=>
            reg_rdata == $past(apb1_periph_reset) &&
            (reg_rdata & ~APB1_RST_MASK) == 32'h0000_0000
    ) else $error("APB1 read data wrong");

    chk_zero_wait: assert property (
        reg_sel && ce |=> reg_ack
    ) else $error("Access not answered on next edge");

    chk_ack_cause: assert property (
        $rose(reg_ack) |-> $past(reg_sel && ce)
    ) else $error("Answer without a request");

    chk_byte_lane: assert property (
        wr_ahb2 && ce && reg_be == 4'h1 |=>
            ahb2_periph_reset[31:8] == $past(ahb2_periph_reset[31:8]) &&
            ahb2_periph_reset[7:0] ==
                ($past(reg_wdata[7:0]) & AHB2_RST_MASK[7:0])
    ) else $error("Byte write touched other lanes");

    chk_apb1_release: assert property (
        s_word_wr(wr_apb1) ##0 reg_wdata == 32'h0000_0000 |=>
            apb1_periph_reset == 32'h0000_0000 && !dac_if_reset
    ) else $error("APB1 clear did not release resets");

    chk_apb1_reserved: assert property (
        s_word_wr(wr_apb1) |=>
            (apb1_periph_reset & ~APB1_RST_MASK) == 32'h0000_0000
    ) else $error("APB1 reserved bit took a write");

endmodule // prc_top

// ### sim/prc_periph_model.sv
// Peripheral-side model: watches software reset lines, records releases
`timescale 1ns/10ps
module prc_periph_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [31:0] hold,
    output logic      [31:0] released
);
    logic [31:0] held_reg;

    // ------------------------------------------------------------------
    // Release tracking
    // ------------------------------------------------------------------
    // A peripheral is released once its line falls after being held; a
    // sticky record lets the bench look after the fact
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            held_reg <= 32'h0000_0000;
            released <= 32'h0000_0000;
        end else begin
            held_reg <= hold;
            released <= released | (held_reg & ~hold);
        end
    end
endmodule // prc_periph_model

// ### sim/prc_top_bench.sv
// Self-checking bench for the peripheral reset control block
`timescale 1ns/10ps
module prc_top_bench;
    import prc_pkg::*;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic        ce    = 1'b1;
    logic        sel   = 1'b0;
    logic        wr    = 1'b0;
    logic [7:0]  addr  = 8'h00;
    logic [3:0]  be    = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        ack;
    logic [31:0] rdata, rel, q;
    wire  [31:0] a2, a3, a1;
    wire  [31:0] a2m = a2 & AHB2_RST_MASK;
    wire  [31:0] a3m = a3 & AHB3_RST_MASK;
    wire  [31:0] a1m = a1 & APB1_RST_MASK;
    int          n_fail = 0;
    int          total_checks = 0;

    always #5 clock = ~clock;

    // Reset lines gathered by register bit so masks compare directly
    prc_top u_prc_top (
        .clock(clock), .rst(rst), .ce(ce), .reg_sel(sel), .reg_wr(wr),
        .reg_addr(addr), .reg_be(be), .reg_wdata(wdata), .reg_ack(ack),
        .reg_rdata(rdata),
        .camera_if_reset(a2[0]), .float_unit_reset(a2[1]),
        .cipher_reset(a2[4]), .digest_engine_reset(a2[5]),
        .random_gen_reset(a2[6]), .usb_fullspeed_reset(a2[7]),
        .ext_memctl_reset(a3[0]),
        .timer2_reset(a1[0]), .timer3_reset(a1[1]), .timer4_reset(a1[2]),
        .timer5_reset(a1[3]), .timer6_reset(a1[4]), .timer7_reset(a1[5]),
        .timer12_reset(a1[6]), .timer13_reset(a1[7]),
        .timer14_reset(a1[8]), .window_watchdog_reset(a1[11]),
        .serial_periph2_reset(a1[14]), .serial_periph3_reset(a1[15]),
        .sync_async_port2_reset(a1[17]), .sync_async_port3_reset(a1[18]),
        .async_port4_reset(a1[19]), .async_port5_reset(a1[20]),
        .two_wire1_reset(a1[21]), .two_wire2_reset(a1[22]),
        .two_wire3_reset(a1[23]), .fieldbus1_reset(a1[25]),
        .fieldbus2_reset(a1[26]), .power_if_reset(a1[28]),
        .dac_if_reset(a1[29])
    );

    prc_periph_model u_prc_periph_model (
        .clock(clock), .rst(rst), .hold(a1m), .released(rel)
    );

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access from a falling edge; answer must come one cycle later
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [3:0] b, input logic [31:0] d);
        sel = 1'b1;
        wr = w;
        addr = a;
        be = b;
        wdata = d;
        @(negedge clock);
        sel = 1'b0;
        chk({31'h0, ack}, 32'h1);
        q = rdata;
        @(negedge clock);
        chk({31'h0, ack}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 4'h0, 32'h0);
        chk(q, exp);
    endtask

    task automatic results;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(AHB2_RST_OFS, AHB2_RST_VAL);
        rd(AHB3_RST_OFS, AHB3_RST_VAL);
        rd(APB1_RST_OFS, APB1_RST_VAL);
        chk(a2m | a3m | a1m, 32'h0);
    endtask

    // All ones everywhere: only documented bits stick and drive lines
    task automatic t_full;
        acc(1'b1, AHB2_RST_OFS, 4'hf, 32'hffff_ffff);
        acc(1'b1, AHB3_RST_OFS, 4'hf, 32'hffff_ffff);
        acc(1'b1, APB1_RST_OFS, 4'hf, 32'hffff_ffff);
        rd(AHB2_RST_OFS, AHB2_RST_MASK);
        rd(AHB3_RST_OFS, AHB3_RST_MASK);
        rd(APB1_RST_OFS, APB1_RST_MASK);
        chk(a2m, AHB2_RST_MASK);
        chk(a3m, AHB3_RST_MASK);
        chk(a1m, APB1_RST_MASK);
    endtask

    // Byte then halfword lanes on the AHB2 register; junk in other lanes
    // falls on reserved bits only, so the mask must keep it out
    task automatic t_ahb2_lanes;
        acc(1'b1, AHB2_RST_OFS, 4'h1, 32'hffff_ff12);
        rd(AHB2_RST_OFS, AHB2_RST_MASK & 32'h0000_0012);
        chk(a2m, AHB2_RST_MASK & 32'h0000_0012);
        acc(1'b1, AHB2_RST_OFS, 4'h3, 32'h0000_ffff);
        rd(AHB2_RST_OFS, AHB2_RST_MASK);
        chk(a2m, AHB2_RST_MASK);
    endtask

    // Clear, then byte and halfword lanes on the timer/serial register
    task automatic t_lanes;
        acc(1'b1, APB1_RST_OFS, 4'hf, 32'h0);
        chk(a1m, 32'h0);
        chk(rel, APB1_RST_MASK);
        acc(1'b1, APB1_RST_OFS, 4'h2, 32'hffff_ffff);
        rd(APB1_RST_OFS, APB1_RST_MASK & 32'h0000_ff00);
        acc(1'b1, APB1_RST_OFS, 4'hc, 32'hffff_ffff);
        rd(APB1_RST_OFS, APB1_RST_MASK & 32'hffff_ff00);
        acc(1'b1, APB1_RST_OFS, 4'h4, 32'h0);
        acc(1'b1, APB1_RST_OFS, 4'h1, 32'h0);
        rd(APB1_RST_OFS, APB1_RST_MASK & 32'hff00_ff00);
        chk(a1m, APB1_RST_MASK & 32'hff00_ff00);
    endtask

    // Unmapped hole between registers: acked, read zero, no side effect
    task automatic t_hole;
        acc(1'b1, 8'h1c, 4'hf, 32'hffff_ffff);
        rd(8'h1c, 32'h0);
        rd(AHB3_RST_OFS, AHB3_RST_MASK);
    endtask

    // Clock enable low: a request is neither answered nor taken
    task automatic t_ce;
        ce = 1'b0;
        sel = 1'b1;
        wr = 1'b1;
        addr = AHB3_RST_OFS;
        be = 4'hf;
        wdata = 32'h0;
        repeat (2) @(negedge clock);
        chk({31'h0, ack}, 32'h0);
        sel = 1'b0;
        ce = 1'b1;
        @(negedge clock);
        chk(a3m, AHB3_RST_MASK);
    endtask

    // Second reset mid-run drops every line
    task automatic t_rerun;
        rst = 1'b1;
        @(negedge clock);
        chk(a2m | a3m | a1m, 32'h0);
        rst = 1'b0;
        @(negedge clock);
        t_reset;
    endtask

    initial begin
        #100us;
        n_fail++;
        results;
    end

    initial begin
        repeat (6) @(negedge clock);
        rst = 1'b0;
        t_reset;
        t_full;
        t_ahb2_lanes;
        t_lanes;
        t_hole;
        t_ce;
        t_rerun;
        results;
    end
endmodule // prc_top_bench
